/* File: shared/wpg_pkg.sv */
// constants for the watermark pause generator
// assumes one core clock; used by every design file
package wpg_pkg;
  localparam int NUM_PORTS   = 76;
  localparam int NUM_PARTS   = 12;
  localparam int NUM_CLASSES = 8;
  localparam int LVL_W       = 16;
  localparam int SEG_BYTES   = 160; // one usage segment
  localparam int FRAG_W      = 128; // 16-byte zero fragment
  localparam int PORT_W      = 7;
  localparam int ADDR_W      = 17;  // byte address
  // threshold/usage word: frames low, segments high
  localparam int FRM_LSB     = 0;
  localparam int SEG_LSB     = 16;
  // port_flow_config fields
  localparam int SHEN_LSB    = 0;   // 12 shared enables
  localparam int FMT_BIT     = 12;  // 0 port, 1 class
  localparam int RIV_LSB     = 16;  // reissue_interval
  // class_partition_map: 4 bits per class
  localparam int MAP_W       = 4;
  // tx_halt_duration_table: time a low, time b high
  localparam int HTA_LSB     = 0;
  localparam int HTB_LSB     = 16;
  // register regions, select = address[16:13]
  localparam logic [3:0] RG_QON  = 4'h0;
  localparam logic [3:0] RG_QOFF = 4'h1;
  localparam logic [3:0] RG_SON  = 4'h2;
  localparam logic [3:0] RG_SOFF = 4'h3;
  localparam logic [3:0] RG_PCFG = 4'h4;
  localparam logic [3:0] RG_MAP  = 4'h5;
  localparam logic [3:0] RG_TAG  = 4'h6;
  localparam logic [3:0] RG_HALT = 4'h7;
  localparam logic [3:0] RG_CST  = 4'h8; // class_state_vector
  // reset values
  localparam logic [31:0] RST_ON   = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_OFF  = 32'h0000_0000;
  localparam logic [31:0] RST_PCFG = 32'h0000_0000;
  localparam logic [31:0] RST_MAP  = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0]  VEC_ON   = 8'hFF;
  localparam logic [7:0]  VEC_OFF  = 8'h00;
  localparam logic [PORT_W-1:0] LAST_PORT = 7'h4B;
  typedef enum logic [1:0] {
    S_EVAL = 2'b01,
    S_HOLD = 2'b10
  } wpg_state_type;
endpackage : wpg_pkg

/* File: core/wpg_queue_eval.sv */
// next pause state of one receive queue
// assumes levels and thresholds stable within the cycle
`timescale 1ns/1ps
module wpg_queue_eval
  import wpg_pkg::*;
(
  input  wire logic [31:0] use_lvl,
  input  wire logic [31:0] on_thr,
  input  wire logic [31:0] off_thr,
  input  wire logic [31:0] sh_lvl,
  input  wire logic [31:0] sh_on,
  input  wire logic [31:0] sh_off,
  input  wire logic        sh_en,
  input  wire logic        cur,
  output logic             nxt
);
  logic q_on, q_lv, s_on, s_lv;
  // either unit at/above on, both below off
  always_comb begin
    q_on = (use_lvl[FRM_LSB+:LVL_W] >= on_thr[FRM_LSB+:LVL_W])
        || (use_lvl[SEG_LSB+:LVL_W] >= on_thr[SEG_LSB+:LVL_W]);
    q_lv = (use_lvl[FRM_LSB+:LVL_W] < off_thr[FRM_LSB+:LVL_W])
        && (use_lvl[SEG_LSB+:LVL_W] < off_thr[SEG_LSB+:LVL_W]);
    s_on = (sh_lvl[FRM_LSB+:LVL_W] >= sh_on[FRM_LSB+:LVL_W])
        || (sh_lvl[SEG_LSB+:LVL_W] >= sh_on[SEG_LSB+:LVL_W]);
    s_lv = (sh_lvl[FRM_LSB+:LVL_W] < sh_off[FRM_LSB+:LVL_W])
        && (sh_lvl[SEG_LSB+:LVL_W] < sh_off[SEG_LSB+:LVL_W]);
  end
  // enter, then leave overrides
  always_comb begin
    nxt = cur;
    if (q_on && (s_on || !sh_en))
      nxt = 1'b1;
    if (q_lv || (sh_en && s_lv))
      nxt = 1'b0;
  end
endmodule : wpg_queue_eval

/* File: core/wpg_core.sv */
// watermark pause generator: sweep, decide, request
// assumes usage levels from same-clock logic for sweep_port
// What this block does
// - on/off pairs per queue and partition
// - either on-unit reached enables pause-on
// - pause ends only when both off met
// - per-queue shared enable, cleared at reset
// - enter: queue on and shared on/disabled
// - leave: queue or shared below off
// - per-port select: port or class pause
// - resend counter reloads, repeats pause-on
// - pause-off same format, same halt times as pause-on
// - class follows one partition, else off
// - port mode: request on zero transitions
// - class mode: request on any change
// - periodic sweep; states update on request
// - indicator and 2-bit tag per port
// - class vector; port mode all/none
// - two 16-bit halt times per port
// - all-zero 16-byte fragment per frame
// - pause frames excluded from accounting
`timescale 1ns/1ps
module wpg_core
  import wpg_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic [ADDR_W-1:0]      avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [3:0]             avs_byteenable,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  output logic [PORT_W-1:0]           sweep_port,
  input  wire logic [NUM_PARTS*32-1:0] queue_usage_level,
  input  wire logic [NUM_PARTS*32-1:0] shared_usage_level,
  output logic                        pause_valid,
  input  wire logic                   pause_ready,
  output logic [PORT_W-1:0]           pause_tx_port,
  output logic                        pause_is_class,
  output logic [1:0]                  pause_format_tag,
  output logic [7:0]                  class_state_vector,
  output logic [LVL_W-1:0]            halt_time_a,
  output logic [LVL_W-1:0]            halt_time_b,
  output logic [FRAG_W-1:0]           pause_fragment,
  output logic                        pause_skip_accounting
);
  //////////////////////////////////////////////////////////////////////
  // configuration tables
  logic [31:0] q_on_q   [NUM_PORTS][NUM_PARTS];
  logic [31:0] q_off_q  [NUM_PORTS][NUM_PARTS];
  logic [31:0] s_on_q   [NUM_PARTS];
  logic [31:0] s_off_q  [NUM_PARTS];
  logic [31:0] pcfg_q   [NUM_PORTS];
  logic [31:0] map_q    [NUM_PORTS];
  logic [1:0]  tag_q    [NUM_PORTS];
  logic [31:0] halt_q   [NUM_PORTS];
  // engine state
  logic [NUM_PARTS-1:0]   pst_q [NUM_PORTS];
  logic [7:0]             pc_q  [NUM_PORTS];
  logic [LVL_W-1:0]       cnt_q [NUM_PORTS];
  wpg_state_type          st_q;
  logic [PORT_W-1:0]      port_q;
  logic                   ack_q;
  logic [31:0]            rdata_q;
  logic                   valid_q;
  logic                   cls_q;
  logic [1:0]             tag_o_q;
  logic [7:0]             vec_q;
  logic [31:0]            halt_o_q;
  logic [PORT_W-1:0]      txp_q;

  //////////////////////////////////////////////////////////////////////
  // bus decode
  logic [3:0]        a_rg;
  logic [PORT_W-1:0] a_qp;
  logic [3:0]        a_pt;
  logic [PORT_W-1:0] a_pp;
  logic              q_ok, s_ok, p_ok, req, wr_go, rd_go;
  assign a_rg  = avs_address[16:13];
  assign a_qp  = avs_address[12:6];
  assign a_pt  = avs_address[5:2];
  assign a_pp  = avs_address[8:2];
  assign q_ok  = (a_qp <= LAST_PORT) && (a_pt < 4'(NUM_PARTS));
  assign s_ok  = (avs_address[12:6] == '0) && (a_pt < 4'(NUM_PARTS));
  assign p_ok  = (avs_address[12:9] == '0) && (a_pp <= LAST_PORT);
  assign req   = avs_read | avs_write;
  assign wr_go = avs_write & ack_q; // lands on the answering edge
  assign rd_go = avs_read & ~ack_q;
  // one wait cycle, then answer
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (be[b]) r[b*8+:8] = n[b*8+:8];
    return r;
  endfunction : merge

  // answer strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) ack_q <= 1'b0;
    else          ack_q <= req & ~ack_q;
  end

  // read data, unmapped reads zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= RST_ZERO;
    end else if (rd_go) begin
      rdata_q <= RST_ZERO;
      case (a_rg)
        RG_QON:  if (q_ok) rdata_q <= q_on_q[a_qp][a_pt];
        RG_QOFF: if (q_ok) rdata_q <= q_off_q[a_qp][a_pt];
        RG_SON:  if (s_ok) rdata_q <= s_on_q[a_pt];
        RG_SOFF: if (s_ok) rdata_q <= s_off_q[a_pt];
        RG_PCFG: if (p_ok) rdata_q <= pcfg_q[a_pp];
        RG_MAP:  if (p_ok) rdata_q <= map_q[a_pp];
        RG_TAG:  if (p_ok) rdata_q <= {30'h0, tag_q[a_pp]};
        RG_HALT: if (p_ok) rdata_q <= halt_q[a_pp];
        RG_CST:  if (p_ok) rdata_q <= {24'h0, pc_q[a_pp]};
        default: rdata_q <= RST_ZERO;
      endcase
    end
  end

  // threshold tables
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NUM_PORTS; p++)
        for (int m = 0; m < NUM_PARTS; m++) begin
          q_on_q[p][m]  <= RST_ON;
          q_off_q[p][m] <= RST_OFF;
        end
      for (int m = 0; m < NUM_PARTS; m++) begin
        s_on_q[m]  <= RST_ON;
        s_off_q[m] <= RST_OFF;
      end
    end else if (wr_go) begin
      if (a_rg == RG_QON && q_ok)
        q_on_q[a_qp][a_pt] <= merge(q_on_q[a_qp][a_pt],
                                    avs_writedata, avs_byteenable);
      if (a_rg == RG_QOFF && q_ok)
        q_off_q[a_qp][a_pt] <= merge(q_off_q[a_qp][a_pt],
                                     avs_writedata, avs_byteenable);
      if (a_rg == RG_SON && s_ok)
        s_on_q[a_pt] <= merge(s_on_q[a_pt], avs_writedata,
                              avs_byteenable);
      if (a_rg == RG_SOFF && s_ok)
        s_off_q[a_pt] <= merge(s_off_q[a_pt], avs_writedata,
                               avs_byteenable);
    end
  end

  // per-port tables; shared enables cleared at reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        pcfg_q[p] <= RST_PCFG;
        map_q[p]  <= RST_MAP;
        tag_q[p]  <= 2'b00;
        halt_q[p] <= RST_ZERO;
      end
    end else if (wr_go && p_ok) begin
      if (a_rg == RG_PCFG)
        pcfg_q[a_pp] <= merge(pcfg_q[a_pp], avs_writedata,
                              avs_byteenable);
      if (a_rg == RG_MAP)
        map_q[a_pp] <= merge(map_q[a_pp], avs_writedata,
                             avs_byteenable);
      if (a_rg == RG_TAG && avs_byteenable[0])
        tag_q[a_pp] <= avs_writedata[1:0];
      if (a_rg == RG_HALT)
        halt_q[a_pp] <= merge(halt_q[a_pp], avs_writedata,
                              avs_byteenable);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // evaluation of the swept port
  logic [NUM_PARTS-1:0] nps;
  logic [7:0]           npc;
  logic [31:0]          cfg;
  logic                 fmt, any_old, any_new, chg, rsnd, fire;
  assign cfg = pcfg_q[port_q];
  assign fmt = cfg[FMT_BIT];

  genvar g;
  generate
    for (g = 0; g < NUM_PARTS; g++) begin : g_part
      wpg_queue_eval u_eval (
        .use_lvl (queue_usage_level[g*32+:32]),
        .on_thr  (q_on_q[port_q][g]),
        .off_thr (q_off_q[port_q][g]),
        .sh_lvl  (shared_usage_level[g*32+:32]),
        .sh_on   (s_on_q[g]),
        .sh_off  (s_off_q[g]),
        .sh_en   (cfg[SHEN_LSB+g]),
        .cur     (pst_q[port_q][g]),
        .nxt     (nps[g])
      );
    end
    // class follows mapped partition or stays off
    for (g = 0; g < NUM_CLASSES; g++) begin : g_cls
      logic [MAP_W-1:0] m;
      assign m      = map_q[port_q][g*MAP_W+:MAP_W];
      assign npc[g] = (m < 4'(NUM_PARTS)) ? nps[m] : 1'b0;
    end
  endgenerate

  // request decision
  assign any_old = |pc_q[port_q];
  assign any_new = |npc;
  assign chg  = fmt ? (pc_q[port_q] != npc)
                    : (any_old != any_new);
  assign rsnd = !chg && any_old && (cnt_q[port_q] == '0);
  assign fire = (st_q == S_EVAL) && (chg || rsnd);

  //////////////////////////////////////////////////////////////////////
  // sweep sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= S_EVAL;
      port_q <= '0;
    end else begin
      case (st_q)
        S_EVAL: begin
          if (fire)
            st_q <= S_HOLD;
          else
            port_q <= (port_q == LAST_PORT) ? '0 : port_q + 1'b1;
        end
        S_HOLD: begin
          if (pause_ready) begin
            st_q   <= S_EVAL;
            port_q <= (port_q == LAST_PORT) ? '0 : port_q + 1'b1;
          end
        end
        default: st_q <= S_EVAL;
      endcase
    end
  end

  // stored partition and class states
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        pst_q[p] <= '0;
        pc_q[p]  <= '0;
      end
    end else if (fire && chg) begin
      pst_q[port_q] <= nps;
      pc_q[port_q]  <= npc;
    end
  end

  // reissue countdown, one step per visit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NUM_PORTS; p++) cnt_q[p] <= '0;
    end else if (st_q == S_EVAL) begin
      if ((chg && any_new) || rsnd)
        cnt_q[port_q] <= cfg[RIV_LSB+:LVL_W];
      else if (any_old && cnt_q[port_q] != '0)
        cnt_q[port_q] <= cnt_q[port_q] - 1'b1;
    end
  end

  // request outputs, held until accepted
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_q  <= 1'b0;
      txp_q    <= '0;
      cls_q    <= 1'b0;
      tag_o_q  <= 2'b00;
      vec_q    <= VEC_OFF;
      halt_o_q <= RST_ZERO;
    end else if (fire) begin
      valid_q  <= 1'b1;
      txp_q    <= port_q;
      cls_q    <= fmt;
      tag_o_q  <= tag_q[port_q];
      halt_o_q <= halt_q[port_q];
      if (fmt)
        vec_q <= chg ? npc : pc_q[port_q];
      else
        vec_q <= (chg ? any_new : 1'b1) ? VEC_ON : VEC_OFF;
    end else if (pause_ready) begin
      valid_q <= 1'b0;
    end
  end

  assign sweep_port         = port_q;
  assign pause_valid        = valid_q;
  assign pause_tx_port      = txp_q;
  assign pause_is_class     = cls_q;
  assign pause_format_tag   = tag_o_q;
  assign class_state_vector = vec_q;
  assign halt_time_a        = halt_o_q[HTA_LSB+:LVL_W];
  assign halt_time_b        = halt_o_q[HTB_LSB+:LVL_W];
  assign pause_fragment     = '0;
  // pause frames never counted against usage or bandwidth
  assign pause_skip_accounting = valid_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_hold;
    pause_valid && !pause_ready |=>
      pause_valid && $stable(class_state_vector) && $stable(pause_tx_port);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");

  property p_port_vec;
    pause_valid && !pause_is_class |->
      class_state_vector == VEC_ON || class_state_vector == VEC_OFF;
  endproperty
  a_port_vec: assert property (p_port_vec) else $error("bad vector");

  property p_step;
    st_q == S_EVAL && !fire && port_q != LAST_PORT |=>
      port_q == $past(port_q) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("sweep skipped");

  property p_fire;
    fire |=> pause_valid && pause_tx_port == $past(port_q)
      && pause_is_class == $past(fmt);
  endproperty
  a_fire: assert property (p_fire) else $error("no request");

  property p_reload;
    fire && rsnd |=> cnt_q[$past(port_q)] == $past(cfg[RIV_LSB+:LVL_W]);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

  property p_store;
    fire && chg |=> pc_q[$past(port_q)] == $past(npc);
  endproperty
  a_store: assert property (p_store) else $error("state lost");

  property p_acct;
    pause_valid |-> pause_skip_accounting && pause_fragment == '0;
  endproperty
  a_acct: assert property (p_acct) else $error("accounting");

  property p_bus;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus stalled");
endmodule : wpg_core

/* File: test/wpg_sched_model.sv */
// egress scheduler model: accepts pause requests, logs the last one
// assumes the request outputs of wpg_core on the same core clock
`timescale 1ns/1ps
module wpg_sched_model
  import wpg_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        stall,
  input  wire logic              pause_valid,
  output logic                   pause_ready,
  input  wire logic [PORT_W-1:0] pause_tx_port,
  input  wire logic              pause_is_class,
  input  wire logic [1:0]        pause_format_tag,
  input  wire logic [7:0]        class_state_vector,
  input  wire logic [LVL_W-1:0]  halt_time_a,
  input  wire logic [FRAG_W-1:0] pause_fragment,
  input  wire logic              pause_skip_accounting,
  output logic [15:0]            taken,
  output logic [33:0]            last_req,
  output logic [7:0]             bad
);
  logic [7:0] wait_q;

  ////////////////////////////////////////////////////////////////////////
  // accept at the next free slot, after stall cycles of busy egress
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pause_ready <= 1'b0;
      wait_q      <= 8'h00;
    end else if (pause_valid && pause_ready) begin
      pause_ready <= 1'b0;
      wait_q      <= 8'h00;
    end else if (pause_valid && wait_q >= stall) begin
      pause_ready <= 1'b1;
    end else if (pause_valid) begin
      wait_q      <= wait_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // log accepted frame fields; frame built from a zero fragment
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      taken    <= 16'h0000;
      last_req <= '0;
      bad      <= 8'h00;
    end else if (pause_valid && pause_ready) begin
      taken    <= taken + 16'h0001;
      last_req <= {halt_time_a, class_state_vector, pause_format_tag,
                   pause_is_class, pause_tx_port};
      // nonzero fragment or counted frame is flagged
      if (pause_fragment !== '0 || pause_skip_accounting !== 1'b1) begin
        bad <= bad + 8'h01;
      end
    end
  end
endmodule : wpg_sched_model

/* File: test/tb_watermark_pause_generator.sv */
// testbench for wpg_core: row table, then resend, stall and reset cases
// assumes port 0 levels on the usage inputs, zero for other ports
`timescale 1ns/1ps
module tb_watermark_pause_generator
  import wpg_pkg::*;
;
  typedef struct packed {
    logic [31:0] pcfg;
    logic [31:0] l0;
    logic [7:0]  l1;
    logic [7:0]  l2;
    logic [7:0]  sh;
    logic        dn;
    logic [7:0]  vec;
    logic        cls;
  } wpg_row_type;
  localparam logic [31:0] PM = 32'hFFFF_0000;
  localparam logic [31:0] SM = 32'hFFFF_0001;
  localparam logic [31:0] CM = 32'hFFFF_1000;
  localparam wpg_row_type ROWS [19] = '{
    '{PM, 32'h0000_0003, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0},
    '{PM, 32'h0000_0004, 8'h00, 8'h00, 8'h00, 1'b1, 8'hFF, 1'b0},
    '{PM, 32'h0000_0003, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0},
    '{PM, 32'h0000_0001, 8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 1'b0},
    '{PM, 32'hFFFF_0000, 8'h00, 8'h00, 8'h00, 1'b1, 8'hFF, 1'b0},
    '{PM, 32'h0000_0000, 8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 1'b0},
    '{PM, 32'h0000_0004, 8'h00, 8'h00, 8'h00, 1'b1, 8'hFF, 1'b0},
    '{PM, 32'h0000_0004, 8'h04, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0},
    '{PM, 32'h0000_0000, 8'h04, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0},
    '{PM, 32'h0000_0000, 8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 1'b0},
    '{SM, 32'h0000_0004, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0},
    '{SM, 32'h0000_0004, 8'h00, 8'h00, 8'h10, 1'b1, 8'hFF, 1'b0},
    '{SM, 32'h0000_0004, 8'h00, 8'h00, 8'h04, 1'b1, 8'h00, 1'b0},
    '{SM, 32'h0000_0000, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0},
    '{CM, 32'h0000_0004, 8'h00, 8'h00, 8'h00, 1'b1, 8'h01, 1'b1},
    '{CM, 32'h0000_0004, 8'h04, 8'h00, 8'h00, 1'b1, 8'h09, 1'b1},
    '{CM, 32'h0000_0000, 8'h04, 8'h00, 8'h00, 1'b1, 8'h08, 1'b1},
    '{CM, 32'h0000_0000, 8'h04, 8'h04, 8'h00, 1'b0, 8'h08, 1'b1},
    '{CM, 32'h0000_0000, 8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 1'b1}};

  logic                   core_clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic [ADDR_W-1:0]      avs_address = '0;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [3:0]             avs_byteenable = 4'hF;
  logic [31:0]            avs_writedata = '0;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic [PORT_W-1:0]      sweep_port;
  logic [NUM_PARTS*32-1:0] queue_usage_level;
  logic [NUM_PARTS*32-1:0] shared_usage_level;
  logic                   pause_valid;
  logic                   pause_ready;
  logic [PORT_W-1:0]      pause_tx_port;
  logic                   pause_is_class;
  logic [1:0]             pause_format_tag;
  logic [7:0]             class_state_vector;
  logic [LVL_W-1:0]       halt_time_a;
  logic [LVL_W-1:0]       halt_time_b;
  logic [FRAG_W-1:0]      pause_fragment;
  logic                   pause_skip_accounting;
  logic [7:0]             stall = 8'h00;
  logic [15:0]            taken;
  logic [33:0]            last_req;
  logic [7:0]             bad;
  logic [31:0]            l0 = '0;
  logic [7:0]             l1 = '0;
  logic [7:0]             l2 = '0;
  logic [7:0]             sh = '0;
  logic [31:0]            rd;
  logic [7:0]             cvec;
  int                     errors = 0;
  int                     total_checks = 0;

  // clock and the usage levels of port 0
  always #2 core_clk = ~core_clk;
  assign queue_usage_level = (sweep_port == 7'h00) ?
      {288'h0, 24'h0, l2, 24'h0, l1, l0} : '0;
  assign shared_usage_level = {352'h0, 24'h0, sh};

  wpg_core i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sweep_port(sweep_port), .queue_usage_level(queue_usage_level),
    .shared_usage_level(shared_usage_level), .pause_valid(pause_valid),
    .pause_ready(pause_ready), .pause_tx_port(pause_tx_port),
    .pause_is_class(pause_is_class), .pause_format_tag(pause_format_tag),
    .class_state_vector(class_state_vector), .halt_time_a(halt_time_a),
    .halt_time_b(halt_time_b), .pause_fragment(pause_fragment),
    .pause_skip_accounting(pause_skip_accounting));

  wpg_sched_model i_sched (.core_clk(core_clk), .reset_n(reset_n),
    .stall(stall), .pause_valid(pause_valid), .pause_ready(pause_ready),
    .pause_tx_port(pause_tx_port), .pause_is_class(pause_is_class),
    .pause_format_tag(pause_format_tag),
    .class_state_vector(class_state_vector), .halt_time_a(halt_time_a),
    .pause_fragment(pause_fragment),
    .pause_skip_accounting(pause_skip_accounting),
    .taken(taken), .last_req(last_req), .bad(bad));

  ////////////////////////////////////////////////////////////////////////
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic we, input logic [3:0] rg, input logic [12:0] off,
           input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address   <= {rg, off};
    avs_write     <= we;
    avs_read      <= !we;
    avs_writedata <= d;
    n = 0;
    // values seen here are those that stood at the edge
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) begin
      errors++;
      $display("ERROR %0t bus transfer hung", $time);
    end
  endtask : bus

  task chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // watchdog against a hung run
  initial begin
    #200000;
    errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    wpg_row_type r;
    int          n;
    logic [15:0] c0;
    cyc(3);
    reset_n <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      bus(1'b1, RG_QON, 13'(p * 4), 32'hFFFF_0004, rd);
      bus(1'b1, RG_QOFF, 13'(p * 4), 32'h0001_0002, rd);
    end
    bus(1'b1, RG_SON, 13'h0000, 32'hFFFF_0010, rd);
    bus(1'b1, RG_SOFF, 13'h0000, 32'h0001_0008, rd);
    bus(1'b1, RG_MAP, 13'h0000, 32'hFFFF_1FF0, rd);
    bus(1'b1, RG_TAG, 13'h0000, 32'h0000_0001, rd);
    bus(1'b1, RG_HALT, 13'h0000, 32'h0022_0011, rd);
    bus(1'b0, RG_HALT, 13'h0000, 32'h0000_0000, rd);
    chk(34'(rd), 34'h0_0022_0011);
    cvec = 8'h00;
    for (int i = 0; i < 19; i++) begin
      r = ROWS[i];
      c0 = taken;
      bus(1'b1, RG_PCFG, 13'h0000, r.pcfg, rd);
      l0 <= r.l0;
      l1 <= r.l1;
      l2 <= r.l2;
      sh <= r.sh;
      cyc(250);
      chk(34'(taken - c0), 34'(r.dn));
      if (r.dn) begin
        cvec = r.vec;
        chk(last_req, {16'h0011, r.vec, 2'b01, r.cls, 7'h00});
        chk(34'(halt_time_b), 34'h0022);
      end
      if (r.cls) begin
        bus(1'b0, RG_CST, 13'h0000, 32'h0000_0000, rd);
        chk(34'(rd), 34'(cvec));
      end
      $display("row %0d done", i);
    end
    chk(34'(bad), 34'h0);
    // resend of pause-on while the queue stays at its on level
    bus(1'b1, RG_PCFG, 13'h0000, 32'h0002_0000, rd);
    c0 = taken;
    l0 <= 32'h0000_0004;
    cyc(1000);
    n = int'(taken - c0);
    chk(34'(n >= 3 && n <= 8), 34'h1);
    chk(34'(last_req[17:10]), 34'h0FF);
    l0 <= 32'h0000_0000;
    cyc(250);
    chk(last_req, {16'h0011, 8'h00, 2'b01, 1'b0, 7'h00});
    $display("resend test done");
    // held request while the scheduler is busy
    bus(1'b1, RG_PCFG, 13'h0000, PM, rd);
    stall <= 8'd10;
    l0 <= 32'h0000_0004;
    n = 0;
    while (pause_valid !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    repeat (5) @(negedge core_clk);
    chk(34'({pause_valid, sweep_port}), 34'h80);
    while (pause_valid === 1'b1 && n < 800) begin
      @(negedge core_clk);
      n++;
    end
    chk(34'(sweep_port), 34'h1);
    @(posedge core_clk);
    l0 <= 32'h0000_0000;
    stall <= 8'd0;
    cyc(250);
    $display("stall test done");
    // second reset, then reset values and refused accesses
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    bus(1'b0, RG_QON, 13'h0000, 32'h0000_0000, rd);
    chk(34'(rd), 34'(RST_ON));
    bus(1'b0, RG_PCFG, 13'h0000, 32'h0000_0000, rd);
    chk(34'(rd), 34'h0);
    bus(1'b0, RG_MAP, 13'h0000, 32'h0000_0000, rd);
    chk(34'(rd), 34'(RST_MAP));
    bus(1'b1, RG_CST, 13'h0000, 32'h0000_00FF, rd);
    bus(1'b0, RG_CST, 13'h0000, 32'h0000_0000, rd);
    chk(34'(rd), 34'h0);
    bus(1'b0, 4'h9, 13'h0000, 32'h0000_0000, rd);
    chk(34'(rd), 34'h0);
    $display("reset test done");
    complete_run();
  end
endmodule : tb_watermark_pause_generator
